// *** shared/afrc_defines.svh ***
// Purpose: offsets, field positions, identity values and timing for the alarm flag bank
// Assumes: ref_clk at 250 MHz; serial frames are MSB first
// Notes: included by its bare name from every design file that needs it
`ifndef AFRC_DEFINES_SVH
`define AFRC_DEFINES_SVH

// register offsets on the serial port
`define AFRC_OFS_SIG_LOSS 8'h83
`define AFRC_OFS_OFFSET_LOCK 8'h84
`define AFRC_OFS_PART_HIGH 8'h86
`define AFRC_OFS_PART_LOW_REV 8'h87
`define AFRC_OFS_RESET_CAL 8'h88

// field positions inside the flag registers and the reset/calibration control register
`define AFRC_BIT_REF_LOS 0
`define AFRC_BIT_IN1_LOS 1
`define AFRC_BIT_IN2_LOS 2
`define AFRC_BIT_LOCK_LOSS 1
`define AFRC_BIT_IN1_FOS 2
`define AFRC_BIT_IN2_FOS 3
`define AFRC_BIT_SOFT_RESET 7
`define AFRC_BIT_CAL_START 6

// index of each alarm in the internal six-bit alarm vector
`define AFRC_ALM_REF_LOS 0
`define AFRC_ALM_IN1_LOS 1
`define AFRC_ALM_IN2_LOS 2
`define AFRC_ALM_LOCK_LOSS 3
`define AFRC_ALM_IN1_FOS 4
`define AFRC_ALM_IN2_FOS 5
`define AFRC_ALARMS 6

// identity values: arbitrary, chosen only to be recognisable in a bench
`define AFRC_PART_NUMBER 12'h5A5
`define AFRC_REVISION 4'h3

// reset values
`define AFRC_FLAGS_RESET 6'h00
`define AFRC_BYTE_RESET 8'h00

// serial frame: command byte, address byte, then data (write) or dummy + data (read)
`define AFRC_CMD_READ_BIT 7
`define AFRC_CNT_CMD_END 5'h07
`define AFRC_CNT_ADDR_END 5'h0F
`define AFRC_CNT_DATA_END 5'h17
`define AFRC_CNT_LAST 5'h1F

// self-calibration time; least time, so rounded up
`define AFRC_REF_CLK_MHZ 250
`define AFRC_CAL_TIME_NS 20000
`define AFRC_CAL_CYCLES ((`AFRC_CAL_TIME_NS * `AFRC_REF_CLK_MHZ + 999) / 1000)

`endif

// *** shared/afrc_pkg.sv ***
// Purpose: types shared by the alarm flag bank modules
// Assumes: constants live in afrc_defines.svh
// Notes: none
package afrc_pkg;

  typedef enum logic [1:0] {
    AFRC_LK_CMD,
    AFRC_LK_ADDR,
    AFRC_LK_DATA,
    AFRC_LK_TAIL
  } afrc_link_phase_t;

  typedef enum logic {
    AFRC_CAL_IDLE,
    AFRC_CAL_RUN
  } afrc_cal_state_t;

endpackage : afrc_pkg

// *** verilog/afrc_sync.sv ***
// Purpose: two-flop synchroniser, one pair of flops per bit
// Assumes: each bit is a level or a toggle, never a multi-bit word
// Notes: first flop feeds only the second
`timescale 1ns/100ps
`default_nettype none

module afrc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_q[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta_q[i] <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end

endmodule : afrc_sync

`default_nettype wire

// *** verilog/afrc_cal.sv ***
// Purpose: self-calibration sequencer; busy while the timed sequence runs
// Assumes: start is a one-cycle pulse on clk
// Notes: a start while busy restarts the sequence from zero
`timescale 1ns/100ps
`default_nettype none
`include "afrc_defines.svh"

module afrc_cal #(
  parameter int unsigned CAL_CYCLES = `AFRC_CAL_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_rst,
  input wire logic start,
  output logic busy_q
);
  import afrc_pkg::*;

  afrc_cal_state_t state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic busy_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (soft_rst) begin
      state_d = AFRC_CAL_IDLE;
      cnt_d = 32'h0;
    end else if (start) begin
      state_d = AFRC_CAL_RUN;
      cnt_d = 32'h0;
    end else begin
      unique case (state_q)
        AFRC_CAL_IDLE: cnt_d = 32'h0;
        AFRC_CAL_RUN: begin
          if (cnt_q >= CAL_CYCLES - 1) begin
            state_d = AFRC_CAL_IDLE;
          end else begin
            cnt_d = cnt_q + 32'h1;
          end
        end
      endcase
    end
    busy_d = (state_d == AFRC_CAL_RUN);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= AFRC_CAL_IDLE;
      cnt_q <= 32'h0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

endmodule : afrc_cal

`default_nettype wire

// *** verilog/afrc_regs.sv ***
// Purpose: sticky alarm flags, identity, soft reset and self-calibration control,
//          reached over a serial port clocked by the host
// Assumes: link_sclk stops while link_cs_n is high; frames are 24 (write) or 32 (read) bits
// Notes: live alarms arrive as asynchronous levels from the monitors
//
// Contract
// R1: input two loss sets sticky bit 2
// R2: input one loss sets sticky bit 1
// R3: reference loss sets sticky bit 0
// R4: input two offset sets bit 3, second register
// R5: input one offset sets bit 2, second register
// R6: lock loss sets bit 1, second register
// R7: writing 0 clears flag; nothing else
// R8: interrupt needs enable and unmasked flag
// R9: twelve-bit part number split across two registers
// R10: four-bit revision below low part bits
// R11: reset bit resets logic, outputs disabled
// R12: host waits 10 ms after reset
// R13: calibration bit starts sequence, self-clears
// R14: lock loss high during calibration, low after
// R15: host supplies stable clock before calibrating
// R16: large input frequency move may recalibrate
// R17: host must calibrate after configuration
// R18: reserved bits are read-only
// R19: live loss bit high while loss seen
// R20: live offset bit high while offset seen
// R21: live lock status one when unlocked
// R22: set wins over a coincident clear
// R23: interrupt is OR of unmasked flags
`timescale 1ns/100ps
`default_nettype none
`include "afrc_defines.svh"

module afrc_regs #(
  parameter int unsigned CAL_CYCLES = `AFRC_CAL_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_sdi,
  output logic link_sdo_q,
  input wire logic input2_signal_loss_live,
  input wire logic input1_signal_loss_live,
  input wire logic reference_signal_loss_live,
  input wire logic input2_freq_offset_live,
  input wire logic input1_freq_offset_live,
  input wire logic pll_unlocked,
  input wire logic input_freq_jump,
  input wire logic int_pin_enable,
  input wire logic input2_signal_loss_mask,
  input wire logic input1_signal_loss_mask,
  input wire logic reference_signal_loss_mask,
  input wire logic input2_freq_offset_mask,
  input wire logic input1_freq_offset_mask,
  input wire logic pll_lock_loss_mask,
  output logic alarm_int_q,
  output logic lock_loss_alarm_q,
  output logic cal_busy_q
);
  import afrc_pkg::*;

  // all pin levels and both request toggles share one synchroniser bank
  localparam int unsigned SYNC_W = 16;

  // ---------------- link domain: serial frame decode ----------------

  logic lk_frame_rst_n;
  logic [4:0] lk_cnt_q, lk_cnt_d;
  logic [7:0] lk_shift_q, lk_shift_d;
  logic lk_rd_q, lk_rd_d;
  logic [7:0] lk_addr_q, lk_addr_d;
  logic [7:0] lk_out_q, lk_out_d;
  logic lk_wr_tog_q, lk_wr_tog_d;
  logic lk_rd_tog_q, lk_rd_tog_d;
  logic [7:0] lk_wr_addr_q, lk_wr_addr_d;
  logic [7:0] lk_wr_data_q, lk_wr_data_d;
  logic [7:0] lk_rd_addr_q, lk_rd_addr_d;
  logic [7:0] lk_in_byte;
  logic link_sdo_d;
  afrc_link_phase_t lk_phase;
  logic [7:0] rd_data_q, rd_data_d;

  // frame state is cleared whenever the select is high, so a torn frame never carries over
  assign lk_frame_rst_n = rst_n & ~link_cs_n;

  always_comb begin
    lk_in_byte = {lk_shift_q[6:0], link_sdi};
    lk_shift_d = lk_in_byte;
    // the count saturates so trailing bits cannot wrap into a new command
    lk_cnt_d = (lk_cnt_q == `AFRC_CNT_LAST) ? lk_cnt_q : lk_cnt_q + 5'h01;
    lk_rd_d = lk_rd_q;
    lk_addr_d = lk_addr_q;
    lk_out_d = {lk_out_q[6:0], 1'b0};
    lk_wr_tog_d = lk_wr_tog_q;
    lk_rd_tog_d = lk_rd_tog_q;
    lk_wr_addr_d = lk_wr_addr_q;
    lk_wr_data_d = lk_wr_data_q;
    lk_rd_addr_d = lk_rd_addr_q;
    if (lk_cnt_q <= `AFRC_CNT_CMD_END) begin
      lk_phase = AFRC_LK_CMD;
    end else if (lk_cnt_q <= `AFRC_CNT_ADDR_END) begin
      lk_phase = AFRC_LK_ADDR;
    end else if (lk_cnt_q <= `AFRC_CNT_DATA_END) begin
      lk_phase = AFRC_LK_DATA;
    end else begin
      lk_phase = AFRC_LK_TAIL;
    end
    unique case (lk_phase)
      AFRC_LK_CMD: begin
        if (lk_cnt_q == `AFRC_CNT_CMD_END) begin
          lk_rd_d = lk_in_byte[`AFRC_CMD_READ_BIT];
        end
      end
      AFRC_LK_ADDR: begin
        if (lk_cnt_q == `AFRC_CNT_ADDR_END) begin
          lk_addr_d = lk_in_byte;
          if (lk_rd_q) begin
            // the read is fetched during the dummy byte, leaving the core eight link clocks
            lk_rd_addr_d = lk_in_byte;
            lk_rd_tog_d = ~lk_rd_tog_q;
          end
        end
      end
      AFRC_LK_DATA: begin
        if (lk_cnt_q == `AFRC_CNT_DATA_END) begin
          if (lk_rd_q) begin
            lk_out_d = rd_data_q;
          end else begin
            lk_wr_addr_d = lk_addr_q;
            lk_wr_data_d = lk_in_byte;
            lk_wr_tog_d = ~lk_wr_tog_q;
          end
        end
      end
      AFRC_LK_TAIL: begin
        lk_shift_d = lk_in_byte;
      end
    endcase
    link_sdo_d = lk_out_q[7];
  end

  always_ff @(posedge link_sclk or negedge lk_frame_rst_n) begin
    if (!lk_frame_rst_n) begin
      lk_cnt_q <= 5'h00;
      lk_shift_q <= `AFRC_BYTE_RESET;
      lk_rd_q <= 1'b0;
      lk_addr_q <= `AFRC_BYTE_RESET;
      lk_out_q <= `AFRC_BYTE_RESET;
    end else begin
      lk_cnt_q <= lk_cnt_d;
      lk_shift_q <= lk_shift_d;
      lk_rd_q <= lk_rd_d;
      lk_addr_q <= lk_addr_d;
      lk_out_q <= lk_out_d;
    end
  end

  // request words persist across frames; they are read by the core only after a toggle edge
  always_ff @(posedge link_sclk or negedge rst_n) begin
    if (!rst_n) begin
      lk_wr_tog_q <= 1'b0;
      lk_rd_tog_q <= 1'b0;
      lk_wr_addr_q <= `AFRC_BYTE_RESET;
      lk_wr_data_q <= `AFRC_BYTE_RESET;
      lk_rd_addr_q <= `AFRC_BYTE_RESET;
    end else begin
      lk_wr_tog_q <= lk_wr_tog_d;
      lk_rd_tog_q <= lk_rd_tog_d;
      lk_wr_addr_q <= lk_wr_addr_d;
      lk_wr_data_q <= lk_wr_data_d;
      lk_rd_addr_q <= lk_rd_addr_d;
    end
  end

  // data changes on the falling edge so the host samples it on the next rising edge
  // sdo returns low by the last edge of a read, since zeros shift in behind the data
  always_ff @(negedge link_sclk or negedge rst_n) begin
    if (!rst_n) begin
      link_sdo_q <= 1'b0;
    end else begin
      link_sdo_q <= link_sdo_d;
    end
  end

  // ---------------- core domain ----------------

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_lvl;
  logic [`AFRC_ALARMS-1:0] live_in;
  logic [`AFRC_ALARMS-1:0] mask;
  logic s_pll_unlocked;
  logic s_jump;
  logic s_int_en;
  logic s_wr_tog;
  logic s_rd_tog;

  // the order of this word fixes the indices used just below
  assign sync_raw = {lk_rd_tog_q, lk_wr_tog_q, int_pin_enable, input_freq_jump,
                     pll_lock_loss_mask, input2_freq_offset_mask, input1_freq_offset_mask,
                     input2_signal_loss_mask, input1_signal_loss_mask,
                     reference_signal_loss_mask, pll_unlocked,
                     input2_freq_offset_live, input1_freq_offset_live,
                     input2_signal_loss_live, input1_signal_loss_live,
                     reference_signal_loss_live};

  afrc_sync #(.W(SYNC_W)) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .async_in(sync_raw),
    .sync_out(sync_lvl)
  );

  assign s_rd_tog = sync_lvl[15];
  assign s_wr_tog = sync_lvl[14];
  assign s_int_en = sync_lvl[13];
  assign s_jump = sync_lvl[12];
  // mask bits are regrouped into alarm vector order
  assign mask = {sync_lvl[10], sync_lvl[9], sync_lvl[11], sync_lvl[8], sync_lvl[7],
                 sync_lvl[6]};
  assign s_pll_unlocked = sync_lvl[5];

  logic wr_seen_q, wr_seen_d;
  logic rd_seen_q, rd_seen_d;
  logic jump_seen_q, jump_seen_d;
  logic wr_ev;
  logic rd_ev;
  logic srst_q, srst_d;
  logic cal_start;
  logic lock_loss_live;
  logic [`AFRC_ALARMS-1:0] clr;
  logic [`AFRC_ALARMS-1:0] flags_q, flags_d;
  logic alarm_int_d;
  logic lock_loss_alarm_d;
  logic [11:0] part_number;
  logic [3:0] revision;

  assign part_number = `AFRC_PART_NUMBER; // R9
  assign revision = `AFRC_REVISION; // R10

  // the soft reset pulse aborts a running sequence so it cannot hold the lock alarm
  afrc_cal #(.CAL_CYCLES(CAL_CYCLES)) u_cal (
    .clk(ref_clk),
    .rst_n(rst_n),
    .soft_rst(srst_q),
    .start(cal_start),
    .busy_q(cal_busy_q)
  );

  always_comb begin
    wr_ev = s_wr_tog ^ wr_seen_q;
    rd_ev = s_rd_tog ^ rd_seen_q;
    wr_seen_d = s_wr_tog;
    rd_seen_d = s_rd_tog;
    jump_seen_d = s_jump;
    // a software reset is a one-cycle pulse: it clears the flags, the outputs and the calibration, but not the edge trackers
    srst_d = wr_ev && (lk_wr_addr_q == `AFRC_OFS_RESET_CAL)
             && lk_wr_data_q[`AFRC_BIT_SOFT_RESET]; // R11
    cal_start = (wr_ev && (lk_wr_addr_q == `AFRC_OFS_RESET_CAL)
                 && lk_wr_data_q[`AFRC_BIT_CAL_START]
                 && !lk_wr_data_q[`AFRC_BIT_SOFT_RESET]) // R13
                || (s_jump && !jump_seen_q); // R16
    // the lock alarm is held high for the whole calibration so software can poll its end
    lock_loss_live = s_pll_unlocked | cal_busy_q; // R14 R21
    // a live pulse shorter than one clock may be missed by the synchroniser
    live_in[`AFRC_ALM_REF_LOS] = sync_lvl[0]; // R19
    live_in[`AFRC_ALM_IN1_LOS] = sync_lvl[1]; // R19
    live_in[`AFRC_ALM_IN2_LOS] = sync_lvl[2]; // R19
    live_in[`AFRC_ALM_IN1_FOS] = sync_lvl[3]; // R20
    live_in[`AFRC_ALM_IN2_FOS] = sync_lvl[4]; // R20
    live_in[`AFRC_ALM_LOCK_LOSS] = lock_loss_live;
    clr = '0;
    // writing 1 leaves a flag alone; reserved bits of the written byte are ignored
    if (wr_ev && (lk_wr_addr_q == `AFRC_OFS_SIG_LOSS)) begin
      clr[`AFRC_ALM_REF_LOS] = ~lk_wr_data_q[`AFRC_BIT_REF_LOS]; // R7 R18
      clr[`AFRC_ALM_IN1_LOS] = ~lk_wr_data_q[`AFRC_BIT_IN1_LOS]; // R7
      clr[`AFRC_ALM_IN2_LOS] = ~lk_wr_data_q[`AFRC_BIT_IN2_LOS]; // R7
    end
    if (wr_ev && (lk_wr_addr_q == `AFRC_OFS_OFFSET_LOCK)) begin
      clr[`AFRC_ALM_LOCK_LOSS] = ~lk_wr_data_q[`AFRC_BIT_LOCK_LOSS]; // R7 R18
      clr[`AFRC_ALM_IN1_FOS] = ~lk_wr_data_q[`AFRC_BIT_IN1_FOS]; // R7
      clr[`AFRC_ALM_IN2_FOS] = ~lk_wr_data_q[`AFRC_BIT_IN2_FOS]; // R7
    end
    // the new alarm is ORed in after the clear, so a coincident event survives
    if (srst_q) begin
      flags_d = `AFRC_FLAGS_RESET; // R11
    end else begin
      flags_d = live_in | (flags_q & ~clr); // R1 R2 R3 R4 R5 R6 R22
    end
    // a masked flag stays set; unmasking it later raises the interrupt
    // outputs are forced inactive while the soft reset pulse is applied
    alarm_int_d = !srst_q && s_int_en && |(flags_q & ~mask); // R8 R23
    lock_loss_alarm_d = !srst_q && lock_loss_live; // R14
    // reads see flags_q; a flag set in this very cycle shows on the next read
    rd_data_d = rd_data_q;
    if (rd_ev) begin
      unique case (lk_rd_addr_q)
        `AFRC_OFS_SIG_LOSS: begin
          rd_data_d = {5'h00, flags_q[`AFRC_ALM_IN2_LOS], flags_q[`AFRC_ALM_IN1_LOS],
                       flags_q[`AFRC_ALM_REF_LOS]}; // R18
        end
        `AFRC_OFS_OFFSET_LOCK: begin
          rd_data_d = {4'h0, flags_q[`AFRC_ALM_IN2_FOS], flags_q[`AFRC_ALM_IN1_FOS],
                       flags_q[`AFRC_ALM_LOCK_LOSS], 1'b0}; // R18
        end
        `AFRC_OFS_PART_HIGH: rd_data_d = part_number[11:4]; // R9
        `AFRC_OFS_PART_LOW_REV: rd_data_d = {part_number[3:0], revision}; // R9 R10
        // both control bits self-clear, so the control register always reads zero
        `AFRC_OFS_RESET_CAL: rd_data_d = `AFRC_BYTE_RESET; // R13 R18
        default: rd_data_d = `AFRC_BYTE_RESET;
      endcase
    end
  end

  // edge trackers are not soft-reset: clearing them would fake a request edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_seen_q <= 1'b0;
      rd_seen_q <= 1'b0;
      jump_seen_q <= 1'b0;
      srst_q <= 1'b0;
      flags_q <= `AFRC_FLAGS_RESET;
      alarm_int_q <= 1'b0;
      lock_loss_alarm_q <= 1'b0;
      rd_data_q <= `AFRC_BYTE_RESET;
    end else begin
      wr_seen_q <= wr_seen_d;
      rd_seen_q <= rd_seen_d;
      jump_seen_q <= jump_seen_d;
      srst_q <= srst_d;
      flags_q <= flags_d;
      alarm_int_q <= alarm_int_d;
      lock_loss_alarm_q <= lock_loss_alarm_d;
      rd_data_q <= rd_data_d;
    end
  end

endmodule : afrc_regs

`default_nettype wire

// *** testbench/afrc_regs_checker.sv ***
// Purpose: port-level assertions for the alarm flag bank
// Assumes: all checks run on ref_clk; link inputs settle between frames
// Notes: bound to afrc_regs at the foot of this file
`timescale 1ns/100ps
`default_nettype none
`include "afrc_defines.svh"

module afrc_regs_checker #(
  parameter int unsigned CAL_CYCLES = `AFRC_CAL_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_cs_n,
  input wire logic link_sdo_q,
  input wire logic pll_unlocked,
  input wire logic input_freq_jump,
  input wire logic int_pin_enable,
  input wire logic alarm_int_q,
  input wire logic lock_loss_alarm_q,
  input wire logic cal_busy_q
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // counts how long the current calibration has run
  logic [15:0] busy_cnt_q;
  logic [15:0] busy_cnt_d;

  always_comb begin
    busy_cnt_d = cal_busy_q ? busy_cnt_q + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_q <= 16'h0000;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end

  a_int_needs_enable: assert property (!int_pin_enable [*5] |=> !alarm_int_q)
    else $error("interrupt active while pin enable is low");
  a_int_rise_cause: assert property ($rose(alarm_int_q) |-> $past(int_pin_enable, 3))
    else $error("interrupt rose without pin enable");
  a_lock_follows_unlock: assert property (pll_unlocked [*5] |=> lock_loss_alarm_q)
    else $error("lock loss alarm low while pll unlocked");
  a_cal_busy_lol: assert property (cal_busy_q && $past(cal_busy_q) |-> lock_loss_alarm_q)
    else $error("lock loss alarm low during calibration");
  a_cal_end_lol: assert property ($fell(cal_busy_q) && !pll_unlocked && $past(pll_unlocked, 4) == 1'b0
    |-> ##[1:3] !lock_loss_alarm_q)
    else $error("lock loss alarm stuck after calibration");
  a_cal_length: assert property ($fell(cal_busy_q) |-> busy_cnt_q == CAL_CYCLES)
    else $error("calibration length wrong");
  a_jump_starts_cal: assert property ($rose(input_freq_jump) |-> ##[1:6] cal_busy_q)
    else $error("frequency jump did not start calibration");
  a_sdo_idle_low: assert property (link_cs_n [*3] |-> !link_sdo_q)
    else $error("serial output active outside a frame");
endmodule : afrc_regs_checker

bind afrc_regs afrc_regs_checker #(.CAL_CYCLES(CAL_CYCLES)) i_afrc_regs_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .link_cs_n(link_cs_n), .link_sdo_q(link_sdo_q),
  .pll_unlocked(pll_unlocked), .input_freq_jump(input_freq_jump),
  .int_pin_enable(int_pin_enable), .alarm_int_q(alarm_int_q),
  .lock_loss_alarm_q(lock_loss_alarm_q), .cal_busy_q(cal_busy_q)
);
`default_nettype wire

// *** testbench/afrc_host_model.sv ***
// Purpose: serial host that writes and reads the alarm flag bank
// Assumes: 30 ns serial clock, stopped low between frames
// Notes: RESET_WAIT_NS is shortened in the bench; the block does not police it
`timescale 1ns/100ps
`default_nettype none
`include "afrc_defines.svh"

module afrc_host_model #(
  parameter int unsigned RESET_WAIT_NS = 10000000
) (
  output logic link_sclk,
  output logic link_cs_n,
  output logic link_sdi,
  input wire logic link_sdo_q
);
  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
    link_sdi = 1'b0;
  end

  task automatic frame(input logic [31:0] bits, input int n, output logic [7:0] rdata);
    rdata = 8'h00;
    #0.7;
    link_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      link_sdi = bits[31-i];
      #15;
      // sample before the rising edge, while the bit still stands
      if (i >= 24) begin
        rdata = {rdata[6:0], link_sdo_q};
      end
      link_sclk = 1'b1;
      #15;
      link_sclk = 1'b0;
    end
    #15;
    link_cs_n = 1'b1;
    link_sdi = ~link_sdi;
    #300;
  endtask : frame

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] junk;
    frame({8'h00, a, d, 8'h00}, 24, junk);
    if (a == `AFRC_OFS_RESET_CAL && d[`AFRC_BIT_SOFT_RESET]) begin
      #(RESET_WAIT_NS);
    end
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    frame({8'h80, a, 16'h0000}, 32, d);
  endtask : read_reg
endmodule : afrc_host_model
`default_nettype wire

// *** testbench/afrc_regs_tb.sv ***
// Purpose: self-checking bench for the alarm flag bank
// Assumes: CAL_CYCLES shortened to 20; alarm vector order as in the defines
// Notes: random alarms, masks and clear patterns from a fixed lfsr seed
`timescale 1ns/100ps
`default_nettype none
`include "afrc_defines.svh"

module afrc_regs_tb;
  localparam logic [11:0] PART = `AFRC_PART_NUMBER;
  localparam logic [3:0] REV = `AFRC_REVISION;
  logic ref_clk, rst_n, link_sclk, link_cs_n, link_sdi, link_sdo_q;
  logic input_freq_jump, int_pin_enable, alarm_int_q, lock_loss_alarm_q, cal_busy_q;
  logic [5:0] live, mask, flags;
  logic [31:0] seed;
  logic [7:0] rd;
  int mismatches, compares;

  always #2 ref_clk = ~ref_clk;

  afrc_regs #(.CAL_CYCLES(20)) i_afrc_regs (
    .ref_clk(ref_clk), .rst_n(rst_n), .link_sclk(link_sclk), .link_cs_n(link_cs_n),
    .link_sdi(link_sdi), .link_sdo_q(link_sdo_q),
    .input2_signal_loss_live(live[2]), .input1_signal_loss_live(live[1]),
    .reference_signal_loss_live(live[0]), .input2_freq_offset_live(live[5]),
    .input1_freq_offset_live(live[4]), .pll_unlocked(live[3]),
    .input_freq_jump(input_freq_jump), .int_pin_enable(int_pin_enable),
    .input2_signal_loss_mask(mask[2]), .input1_signal_loss_mask(mask[1]),
    .reference_signal_loss_mask(mask[0]), .input2_freq_offset_mask(mask[5]),
    .input1_freq_offset_mask(mask[4]), .pll_lock_loss_mask(mask[3]),
    .alarm_int_q(alarm_int_q), .lock_loss_alarm_q(lock_loss_alarm_q), .cal_busy_q(cal_busy_q)
  );

  afrc_host_model #(.RESET_WAIT_NS(2000)) i_afrc_host_model (
    .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_sdi(link_sdi), .link_sdo_q(link_sdo_q)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    i_afrc_host_model.read_reg(a, rd);
    check($sformatf("reg %h", a), rd, exp);
    tick(1);
  endtask : rd_check

  task automatic chk_flags();
    rd_check(`AFRC_OFS_SIG_LOSS, {5'h00, flags[2:0]});
    rd_check(`AFRC_OFS_OFFSET_LOCK, {4'h0, flags[5:3], 1'b0});
  endtask : chk_flags

  task automatic wait_busy(input logic v);
    for (int k = 0; k < 200 && cal_busy_q !== v; k++) begin
      tick(1);
    end
    check("cal_busy", {7'h00, cal_busy_q}, {7'h00, v});
  endtask : wait_busy

  task automatic report_and_stop();
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #300000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    live = 6'h00;
    mask = 6'h00;
    flags = 6'h00;
    input_freq_jump = 1'b0;
    int_pin_enable = 1'b0;
    seed = 32'h3D2F;
    mismatches = 0;
    compares = 0;
    tick(2);
    rst_n = 1'b1;
    tick(4);
    rd_check(`AFRC_OFS_PART_HIGH, PART[11:4]);
    i_afrc_host_model.write_reg(`AFRC_OFS_PART_LOW_REV, 8'h00);
    rd_check(`AFRC_OFS_PART_LOW_REV, {PART[3:0], REV});
    rd_check(8'h85, 8'h00);
    chk_flags();
    // every alarm held high across a clearing write: the set must win
    // the alarm is dropped so that its last sampled high meets the clear in the core
    for (int w = 0; w < 2; w++) begin
      tick(1);
      live = w ? 6'h38 : 6'h07;
      tick(8);
      fork
        i_afrc_host_model.write_reg(w ? `AFRC_OFS_OFFSET_LOCK : `AFRC_OFS_SIG_LOSS, 8'h00);
        begin
          repeat (24) @(posedge link_sclk);
          @(posedge ref_clk);
          #1;
          live = 6'h00;
        end
      join
    end
    flags = 6'h3F;
    tick(4);
    chk_flags();
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      mask = seed[13:8];
      int_pin_enable = seed[14];
      tick(6);
      check("int", {7'h00, alarm_int_q}, {7'h00, int_pin_enable & |(flags & ~mask)});
      seed = lfsr(seed);
      i_afrc_host_model.write_reg(`AFRC_OFS_SIG_LOSS, seed[7:0]);
      i_afrc_host_model.write_reg(`AFRC_OFS_OFFSET_LOCK, seed[15:8]);
      flags = flags & {seed[11:9], seed[2:0]};
      chk_flags();
      seed = lfsr(seed);
      live = seed[5:0];
      tick(8);
      flags = flags | live;
      live = 6'h00;
      tick(4);
      chk_flags();
    end
    fork
      i_afrc_host_model.write_reg(`AFRC_OFS_RESET_CAL, 8'h40);
      begin
        // the sequence ends inside the frame's tail, so watch from the last data edge
        repeat (24) @(posedge link_sclk);
        wait_busy(1'b1);
        tick(1);
        check("lol_cal", {7'h00, lock_loss_alarm_q}, 8'h01);
        wait_busy(1'b0);
        tick(3);
        check("lol_done", {7'h00, lock_loss_alarm_q}, 8'h00);
      end
    join
    rd_check(`AFRC_OFS_RESET_CAL, 8'h00);
    input_freq_jump = 1'b1;
    wait_busy(1'b1);
    input_freq_jump = 1'b0;
    wait_busy(1'b0);
    // raise every flag and the interrupt first, so the soft reset has work to undo
    mask = 6'h00;
    int_pin_enable = 1'b1;
    live = 6'h3F;
    tick(8);
    live = 6'h00;
    tick(4);
    check("int_pre", {7'h00, alarm_int_q}, 8'h01);
    i_afrc_host_model.write_reg(`AFRC_OFS_RESET_CAL, 8'h80);
    flags = 6'h00;
    chk_flags();
    check("int_rst", {7'h00, alarm_int_q}, 8'h00);
    report_and_stop();
  end
endmodule : afrc_regs_tb
`default_nettype wire
